// ---- verilog/tec_pkg.sv ----
// Constants, register map and types for the eight-bit timer/event counter
package tec_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int unsigned     ADDR_W       = 16;
    localparam logic [15:0]     OFS_CTRL     = 16'hff53;
    localparam logic [15:0]     OFS_MATCH    = 16'hff52;
    localparam logic [15:0]     OFS_COUNT    = 16'hff51;

    // ------------------------------------------------------------------
    // Control register fields and reset values
    // ------------------------------------------------------------------
    localparam int unsigned     BIT_RUN      = 7;
    localparam int unsigned     BIT_PWM      = 6;
    localparam int unsigned     BIT_SRC_HI   = 2;
    localparam int unsigned     BIT_SRC_LO   = 1;
    localparam int unsigned     BIT_OUT_EN   = 0;
    localparam logic [7:0]      CTRL_MASK    = 8'hc7;
    localparam logic [7:0]      CTRL_RST     = 8'h00;
    localparam logic [7:0]      COUNT_RST    = 8'h00;
    localparam logic [7:0]      READ_ZERO    = 8'h00;

    // ------------------------------------------------------------------
    // Count source and prescaler
    // ------------------------------------------------------------------
    localparam logic [1:0]      SRC_CLK      = 2'h0;
    localparam logic [1:0]      SRC_DIV256   = 2'h1;
    localparam logic [1:0]      SRC_RISE     = 2'h2;
    localparam logic [1:0]      SRC_FALL     = 2'h3;
    localparam int unsigned     PRESCALE_DIV = 256;
    localparam logic [7:0]      PRESCALE_LST = 8'(PRESCALE_DIV - 1);
    localparam logic [7:0]      PRESCALE_RST = 8'h00;

    // ------------------------------------------------------------------
    // Operating state
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        TEC_ST_STOP  = 3'h1,
        TEC_ST_TIMER = 3'h2,
        TEC_ST_PWM   = 3'h4
    } tec_state_t;

endpackage

// ---- verilog/tec_edge_sync.sv ----
// Two-stage synchroniser and edge detector for the external event input
`timescale 1ns/1ns
module tec_edge_sync (
    input  wire logic clk_sys_i,
    input  wire logic reset_i,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
        logic rise;
        logic fall;
    } tec_sync_state_t;

    tec_sync_state_t st_q;
    tec_sync_state_t st_d;

    // ------------------------------------------------------------------
    // Sync chain; the second stage and the third (prev) stage feed the edge compare
    // ------------------------------------------------------------------
    always_comb begin
        st_d      = st_q;
        st_d.meta = pin_i;
        st_d.sync = st_q.meta;
        st_d.prev = st_q.sync;
        st_d.rise = st_q.sync & ~st_q.prev;
        st_d.fall = ~st_q.sync & st_q.prev;
        if (reset_i) begin
            st_d = '0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        st_q <= st_d;
    end

    assign level_o = st_q.prev;
    assign rise_o  = st_q.rise;
    assign fall_o  = st_q.fall;

endmodule

// ---- verilog/tec_timer.sv ----
// Eight-bit timer/event counter with match value, control register and PWM
`timescale 1ns/1ns
module tec_timer (
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    input  wire logic [15:0] addr_i,
    input  wire logic        wr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        bit_wr_i,
    input  wire logic [2:0]  bit_idx_i,
    input  wire logic        bit_val_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    output logic             rvalid_o,
    input  wire logic        event_in_pin_i,
    output logic             wave_out_pin_o,
    output logic             wave_out_oe_o,
    output logic             match_irq_o,
    output logic      [7:0]  event_count_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]          ctrl;
        logic [7:0]          match;
        logic [7:0]          count;
        logic [7:0]          prescale;
        tec_pkg::tec_state_t state;
        logic                wave;
        logic                irq;
        logic                oe;
        logic [7:0]          rdata;
        logic                rvalid;
    } tec_timer_state_t;

    tec_timer_state_t st_q;
    tec_timer_state_t st_d;

    logic ev_rise;
    logic ev_fall;

    // ------------------------------------------------------------------
    // Event input conditioning
    // ------------------------------------------------------------------
    tec_edge_sync u_event_sync (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .pin_i     (event_in_pin_i),
        .level_o   (),
        .rise_o    (ev_rise),
        .fall_o    (ev_fall)
    );

    // ------------------------------------------------------------------
    // Decoded control fields
    // ------------------------------------------------------------------
    logic       count_run;
    logic       pwm_mode_sel;
    logic [1:0] count_src_sel;
    logic       wave_out_en;

    assign count_run     = st_q.ctrl[tec_pkg::BIT_RUN];
    assign pwm_mode_sel  = st_q.ctrl[tec_pkg::BIT_PWM];
    assign count_src_sel = {st_q.ctrl[tec_pkg::BIT_SRC_HI],
                            st_q.ctrl[tec_pkg::BIT_SRC_LO]};
    assign wave_out_en   = st_q.ctrl[tec_pkg::BIT_OUT_EN];

    // ------------------------------------------------------------------
    // Count tick selection
    // ------------------------------------------------------------------
    logic div_tick;
    logic tick;

    assign div_tick = (st_q.prescale == tec_pkg::PRESCALE_LST);

    always_comb begin
        case (count_src_sel)
            tec_pkg::SRC_CLK:    tick = 1'b1;
            tec_pkg::SRC_DIV256: tick = div_tick;
            tec_pkg::SRC_RISE:   tick = ev_rise;
            tec_pkg::SRC_FALL:   tick = ev_fall;
            default:             tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------------
    logic hit_ctrl;
    logic hit_match;
    logic hit_count;

    assign hit_ctrl  = (addr_i == tec_pkg::OFS_CTRL);
    assign hit_match = (addr_i == tec_pkg::OFS_MATCH);
    assign hit_count = (addr_i == tec_pkg::OFS_COUNT);

    // Next control value: byte write wins over a bit write in one cycle
    logic [7:0] ctrl_nxt;

    always_comb begin
        ctrl_nxt = st_q.ctrl;
        if (wr_i && hit_ctrl) begin
            ctrl_nxt = wdata_i & tec_pkg::CTRL_MASK;
        end else if (bit_wr_i && hit_ctrl) begin
            ctrl_nxt[bit_idx_i] = bit_val_i;
            ctrl_nxt            = ctrl_nxt & tec_pkg::CTRL_MASK;
        end
    end

    // Operating state follows the next control value, on the same edge as the register
    tec_pkg::tec_state_t state_nxt;

    always_comb begin
        if (!ctrl_nxt[tec_pkg::BIT_RUN]) begin
            state_nxt = tec_pkg::TEC_ST_STOP;
        end else if (ctrl_nxt[tec_pkg::BIT_PWM]) begin
            state_nxt = tec_pkg::TEC_ST_PWM;
        end else begin
            state_nxt = tec_pkg::TEC_ST_TIMER;
        end
    end

    // ------------------------------------------------------------------
    // Counter, match and output logic
    // ------------------------------------------------------------------
    logic       is_match;
    logic [7:0] count_inc;

    assign is_match  = (st_q.count == st_q.match);
    assign count_inc = st_q.count + 8'h01;

    always_comb begin
        st_d        = st_q;
        st_d.irq    = 1'b0;
        st_d.rvalid = 1'b0;
        st_d.ctrl   = ctrl_nxt;
        st_d.state  = state_nxt;

        // Match value accepts any byte
        if (wr_i && hit_match) begin
            st_d.match = wdata_i;
        end

        case (st_q.state)
            tec_pkg::TEC_ST_STOP: begin
                st_d.count    = tec_pkg::COUNT_RST;
                st_d.prescale = tec_pkg::PRESCALE_RST;
                st_d.wave     = 1'b0;
            end
            tec_pkg::TEC_ST_TIMER: begin
                st_d.prescale = st_q.prescale + 8'h01;
                if (tick) begin
                    if (is_match) begin
                        st_d.count = tec_pkg::COUNT_RST;
                        st_d.irq   = 1'b1;
                        st_d.wave  = ~st_q.wave;
                    end else begin
                        st_d.count = count_inc;
                    end
                end
            end
            tec_pkg::TEC_ST_PWM: begin
                st_d.prescale = st_q.prescale + 8'h01;
                if (tick) begin
                    st_d.count = count_inc;
                    st_d.irq   = is_match;
                    st_d.wave  = (count_inc < st_q.match);
                end
            end
            default: begin
                st_d.count    = tec_pkg::COUNT_RST;
                st_d.prescale = tec_pkg::PRESCALE_RST;
                st_d.wave     = 1'b0;
            end
        endcase

        // Leaving run mode drops the output at once
        if (!ctrl_nxt[tec_pkg::BIT_RUN]) begin
            st_d.wave = 1'b0;
        end

        // Timer drives the shared pin only with a clock source
        st_d.oe = ctrl_nxt[tec_pkg::BIT_OUT_EN]
                  & ~ctrl_nxt[tec_pkg::BIT_SRC_HI];

        // Byte read answers one cycle later
        if (rd_i) begin
            st_d.rvalid = 1'b1;
            if (hit_count) begin
                st_d.rdata = st_q.count;
            end else if (hit_ctrl) begin
                st_d.rdata = {count_run, pwm_mode_sel, 3'h0, count_src_sel, wave_out_en};
            end else begin
                st_d.rdata = tec_pkg::READ_ZERO;
            end
        end

        // Reset leaves the match value as it was
        if (reset_i) begin
            st_d          = '0;
            st_d.ctrl     = tec_pkg::CTRL_RST;
            st_d.count    = tec_pkg::COUNT_RST;
            st_d.prescale = tec_pkg::PRESCALE_RST;
            st_d.state    = tec_pkg::TEC_ST_STOP;
            st_d.rdata    = tec_pkg::READ_ZERO;
            st_d.match    = st_q.match;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        st_q <= st_d;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rdata_o        = st_q.rdata;
    assign rvalid_o       = st_q.rvalid;
    assign wave_out_pin_o = st_q.wave;
    assign wave_out_oe_o  = st_q.oe;
    assign match_irq_o    = st_q.irq;
    assign event_count_o  = st_q.count;

endmodule

// ---- tb/tec_timer_sva.sv ----
// Port assertions for the timer/event counter
`timescale 1ns/1ns
module tec_timer_sva (
    input wire logic        clk_sys_i,
    input wire logic        reset_i,
    input wire logic [15:0] addr_i,
    input wire logic        wr_i,
    input wire logic [7:0]  wdata_i,
    input wire logic        bit_wr_i,
    input wire logic [2:0]  bit_idx_i,
    input wire logic        bit_val_i,
    input wire logic        rd_i,
    input wire logic [7:0]  rdata_o,
    input wire logic        rvalid_o,
    input wire logic        wave_out_pin_o,
    input wire logic        wave_out_oe_o,
    input wire logic        match_irq_o,
    input wire logic [7:0]  event_count_o
);
    logic [7:0] c_q;
    logic [7:0] m_q;
    wire        tk = c_q[7] & ~c_q[6] & (c_q[2:1] == 2'h0);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    // Shadow of control and match value, built from bus writes
    always_ff @(posedge clk_sys_i) begin
        if (reset_i)
            c_q <= 8'h00;
        else if (wr_i && addr_i == 16'hff53)
            c_q <= wdata_i & 8'hc7;
        else if (bit_wr_i && addr_i == 16'hff53 && tec_pkg::CTRL_MASK[bit_idx_i])
            c_q[bit_idx_i] <= bit_val_i;
        if (wr_i && addr_i == 16'hff52)
            m_q <= wdata_i;
    end
    chk_read_answer: assert property (rd_i |=> rvalid_o) else $error("read answer missing");
    chk_count_read: assert property (rd_i && addr_i == 16'hff51 |=> rdata_o == $past(event_count_o))
        else $error("count read wrong");
    chk_ctrl_read: assert property (rd_i && addr_i == 16'hff53 |=> rdata_o == $past(c_q))
        else $error("control read wrong");
    chk_stop_zero: assert property (!c_q[7] |=> event_count_o == 8'h00 && !wave_out_pin_o)
        else $error("stopped counter not cleared");
    chk_tick_up: assert property (tk && event_count_o != m_q |=> event_count_o == $past(event_count_o) + 8'h01)
        else $error("count did not step");
    chk_match_irq: assert property (tk && event_count_o == m_q |=> match_irq_o) else $error("no match request");
    chk_irq_clear: assert property (match_irq_o && !c_q[6] |-> event_count_o == 8'h00)
        else $error("match did not clear count");
    chk_wave_flip: assert property (match_irq_o && !c_q[6] |-> wave_out_pin_o != $past(wave_out_pin_o))
        else $error("wave did not invert");
    chk_pwm_level: assert property (c_q[7] && c_q[6] && event_count_o != 8'h00 |->
        wave_out_pin_o == (event_count_o < m_q)) else $error("pwm level wrong");
    chk_oe_follow: assert property (c_q == $past(c_q) |-> wave_out_oe_o == (c_q[0] & ~c_q[2]))
        else $error("output enable wrong");
    cover property (match_irq_o && c_q[2:1] == 2'h1);
    cover property (rvalid_o && c_q[2]);
    cover property (c_q[6] && $rose(wave_out_pin_o));
endmodule
bind tec_timer tec_timer_sva i_sva (.clk_sys_i, .reset_i, .addr_i, .wr_i, .wdata_i, .bit_wr_i, .bit_idx_i,
    .bit_val_i, .rd_i, .rdata_o, .rvalid_o, .wave_out_pin_o, .wave_out_oe_o, .match_irq_o, .event_count_o);

// ---- tb/tec_event_src.sv ----
// Far-side pulse source driving the external event pin
`timescale 1ns/1ns
module tec_event_src (
    input wire logic       clk_sys_i,
    input wire logic       go_i,
    input wire logic [7:0] n_i,
    input wire logic [7:0] half_i,
    output logic           event_in_pin_o,
    output logic           busy_o
);
    // Pin moves on the clock edge; the design's synchroniser takes it from there
    initial begin
        event_in_pin_o <= 1'b0;
        busy_o = 1'b0;
        forever begin
            @(posedge clk_sys_i);
            if (go_i) begin
                busy_o = 1'b1;
                repeat (n_i) begin
                    repeat (half_i) @(posedge clk_sys_i);
                    event_in_pin_o <= 1'b1;
                    repeat (half_i) @(posedge clk_sys_i);
                    event_in_pin_o <= 1'b0;
                end
                busy_o = 1'b0;
            end
        end
    end
endmodule

// ---- tb/test_eight_bit_timer_event_counter.sv ----
// Self-checking bench for the timer/event counter
`timescale 1ns/1ns
module test_eight_bit_timer_event_counter;
    logic        clk_sys_i, reset_i, wr_i, bit_wr_i, bit_val_i, rd_i, go;
    logic [15:0] addr_i;
    logic [7:0]  wdata_i, n, half, m;
    logic [2:0]  bit_idx_i;
    wire  [7:0]  rdata_o, event_count_o;
    wire         rvalid_o, wave_out_pin_o, wave_out_oe_o, match_irq_o, pin, busy;
    logic [7:0]  exp_q[$];
    int          failures, n_tests, seed, k, g, c;

    tec_timer i_dut (.clk_sys_i, .reset_i, .addr_i, .wr_i, .wdata_i, .bit_wr_i, .bit_idx_i, .bit_val_i, .rd_i,
        .rdata_o, .rvalid_o, .event_in_pin_i(pin), .wave_out_pin_o, .wave_out_oe_o, .match_irq_o, .event_count_o);
    tec_event_src i_src (.clk_sys_i, .go_i(go), .n_i(n), .half_i(half), .event_in_pin_o(pin), .busy_o(busy));

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(string s, logic [15:0] e, logic [15:0] v);
        n_tests++;
        if (v !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, v);
        end
    endtask

    task automatic report_and_stop;
        if (failures == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask

    task automatic bw(logic [2:0] i, logic v);
        @(posedge clk_sys_i);
        addr_i <= 16'hff53;
        bit_idx_i <= i;
        bit_val_i <= v;
        bit_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        bit_wr_i <= 1'b0;
    endtask

    task automatic rd(logic [15:0] a, logic [7:0] e);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
    endtask

    // Cycles from one match request to the next
    task automatic gap(output int cnt);
        cnt = 0;
        k = 0;
        while (match_irq_o !== 1'b1 && k < 2000) begin
            @(negedge clk_sys_i);
            k++;
        end
        do begin
            @(negedge clk_sys_i);
            cnt++;
        end while (match_irq_o !== 1'b1 && cnt < 2000);
    endtask

    always @(negedge clk_sys_i) begin
        if (rvalid_o === 1'b1)
            chk("read data", exp_q.size() ? exp_q.pop_front() : 8'hxx, rdata_o);
    end

    initial begin
        #400000;
        failures++;
        report_and_stop;
    end

    initial begin
        {reset_i, wr_i, bit_wr_i, bit_val_i, rd_i, go} = 6'h20;
        {addr_i, wdata_i, bit_idx_i, n, half} = '0;
        {failures, n_tests, seed} = {32'h0, 32'h0, 32'hc3aeb1b0};
        repeat (6) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        rd(16'hff53, 8'h00);
        rd(16'hff51, 8'h00);
        rd(16'hff50, 8'h00);
        wr(16'hff53, 8'h3e);
        rd(16'hff53, 8'h06);
        bw(3'h0, 1'b1);
        bw(3'h2, 1'b0);
        bw(3'h4, 1'b1);
        rd(16'hff53, 8'h03);
        wr(16'hff51, 8'h55);
        rd(16'hff51, 8'h00);
        rd(16'hff52, 8'h00);
        for (g = 0; g < 2; g++) begin
            m = (g == 0) ? 8'(3 + ($random(seed) & 15)) : 8'h01;
            wr(16'hff53, {6'h00, g[0], 1'b1});
            wr(16'hff52, m);
            bw(3'h7, 1'b1);
            gap(c);
            chk("interval", 16'((m + 1) << (8 * g)), c[15:0]);
            chk("output enable", 16'h1, wave_out_oe_o);
            bw(3'h7, 1'b0);
            repeat (2) @(negedge clk_sys_i);
            chk("stopped count", 16'h0, event_count_o);
            chk("stopped wave", 16'h0, wave_out_pin_o);
        end
        for (g = 2; g < 4; g++) begin
            wr(16'hff53, {5'h00, g[1:0], 1'b1});
            wr(16'hff52, 8'hff);
            bw(3'h7, 1'b1);
            n = 8'(1 + ($random(seed) & 15));
            half = 8'(1 + ($random(seed) & 7));
            @(posedge clk_sys_i);
            go <= 1'b1;
            @(posedge clk_sys_i);
            go <= 1'b0;
            k = 0;
            do begin
                @(negedge clk_sys_i);
                k++;
            end while (busy && k < 1000);
            chk("event source idle", 16'h0, busy);
            repeat (4) @(negedge clk_sys_i);
            rd(16'hff51, n);
            chk("pin shared", 16'h0, wave_out_oe_o);
            bw(3'h7, 1'b0);
        end
        m = 8'($random(seed)) | 8'h01;
        wr(16'hff53, 8'h41);
        wr(16'hff52, m);
        bw(3'h7, 1'b1);
        repeat (300) @(negedge clk_sys_i);
        c = 0;
        repeat (256) begin
            @(negedge clk_sys_i);
            c += wave_out_pin_o;
        end
        chk("pwm duty", 16'(m), c[15:0]);
        bw(3'h7, 1'b0);
        repeat (3) @(negedge clk_sys_i);
        report_and_stop;
    end
endmodule
